// file: shared/synth_serial_mod_loader_params.svh
// Constants for the serial register and modulation sample loader
`ifndef SYNTH_SERIAL_MOD_LOADER_PARAMS_SVH
`define SYNTH_SERIAL_MOD_LOADER_PARAMS_SVH

// Frame geometry
`define FRAME_BITS        5'h10
`define SHORT_MIN_BITS    5'h02
`define SHORT_MAX_BITS    5'h0C
`define LEN_SAT           5'h1F
`define ADDR_MSB          15
`define ADDR_LSB          12
`define DATA_MSB          11
`define DATA_BITS         12

// Register addresses
`define REG_COUNT         10
`define ADDR_MAIN_INT     4'h0
`define ADDR_MAIN_FRAC_HI 4'h1
`define ADDR_MAIN_FRAC_LO 4'h2
`define ADDR_AUX_INT      4'h3
`define ADDR_AUX_FRAC     4'h4
`define ADDR_REF_DIV      4'h5
`define ADDR_DET_GAIN     4'h6
`define ADDR_PWR_OUTSEL   4'h7
`define ADDR_MOD_CTRL     4'h8
`define ADDR_MOD_SAMPLE   4'h9

// Reset values
`define RST_INT_DIVIDER   12'h0006
`define RST_OTHER         12'h0000

// Fields
`define FRAC_HI_MSB       9
`define FRAC_LO_MSB       7
`define MODCTL_SRC_BIT    0
`define MODCTL_MAG_MSB    3
`define MODCTL_MAG_LSB    1
`define OFFSET_BITS       20

// Pin synchroniser lanes and their idle levels
`define PIN_SCLK          0
`define PIN_CS_N          1
`define PIN_SDATA         2
`define PIN_MOD           3
`define PIN_VCO           4
`define PIN_COUNT         5
`define PIN_IDLE          5'h02

// Sample buffer
`define BUF_DEPTH         2

`endif

// file: shared/synth_serial_mod_loader_pkg.sv
// Types used by the serial loader; its sample buffer uses none of them
package synth_serial_mod_loader_pkg;

   // Frame handling states
   typedef enum logic [1:0]
   {
      ST_IDLE   = 2'b00,
      ST_SHIFT  = 2'b01,
      ST_DECODE = 2'b10
   } frame_state_t;

   typedef logic signed [11:0] sample_t;
   typedef logic        [3:0]  reg_addr_t;
   typedef logic        [11:0] reg_word_t;

endpackage : synth_serial_mod_loader_pkg

// file: shared/sample_stream_if.sv
// Valid/ready stream between the loader and its sample buffer
`timescale 1ns/10ps
`default_nettype none

interface sample_stream_if #(
   parameter int WIDTH = 12,
   parameter int CNT_W = 2
);
   logic             wr_valid;
   logic             wr_ready;
   logic [WIDTH-1:0] wr_data;
   logic             rd_valid;
   logic             rd_ready;
   logic [WIDTH-1:0] rd_data;
   logic [CNT_W-1:0] rd_count;

   // Buffer side
   modport buffer_side
   (
      input  wr_valid,
      output wr_ready,
      input  wr_data,
      output rd_valid,
      input  rd_ready,
      output rd_data,
      output rd_count
   );

   // Loader side
   modport user_side
   (
      output wr_valid,
      input  wr_ready,
      output wr_data,
      input  rd_valid,
      output rd_ready,
      input  rd_data,
      input  rd_count
   );
endinterface : sample_stream_if

`default_nettype wire

// file: rtl/sample_buffer.sv
// Small flip-flop FIFO for modulation samples
`timescale 1ns/10ps
`default_nettype none

module sample_buffer #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 2
)
(
   // Clock and reset
   input  wire logic          mclk_in,
   input  wire logic          rst_in,
   // Stream
   sample_stream_if.buffer_side st
);
   localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CNT_W = $clog2(DEPTH + 1);
   localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);
   localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

   logic [WIDTH-1:0] mem_r [0:DEPTH-1];
   logic [PTR_W-1:0] wr_ptr_r;
   logic [PTR_W-1:0] rd_ptr_r;
   logic [CNT_W-1:0] count_r;
   logic             push;
   logic             pop;

   // Handshakes; full and empty come straight from the count
   assign st.wr_ready = (count_r != FULL);
   assign st.rd_valid = (count_r != '0);
   assign st.rd_data  = mem_r[rd_ptr_r];
   assign st.rd_count = count_r;
   assign push        = st.wr_valid & st.wr_ready;
   assign pop         = st.rd_valid & st.rd_ready;

   // Storage, written at the write index only
   always_ff @(posedge mclk_in)
   begin
      if (push)
      begin
         mem_r[wr_ptr_r] <= st.wr_data;
      end
   end

   // Pointers wrap explicitly so any depth works
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_r <= (wr_ptr_r == LAST) ? '0 : wr_ptr_r + 1'b1;
         if (pop)
            rd_ptr_r <= (rd_ptr_r == LAST) ? '0 : rd_ptr_r + 1'b1;
         if (push && !pop)
            count_r <= count_r + 1'b1;
         else if (pop && !push)
            count_r <= count_r - 1'b1;
      end
   end
endmodule : sample_buffer

`default_nettype wire

// file: rtl/synth_serial_mod_loader.sv
// Three-wire register loader with direct modulation sample path
`timescale 1ns/10ps
`default_nettype none
`include "synth_serial_mod_loader_params.svh"

module synth_serial_mod_loader
(
   // Clock and reset
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   // Serial pins
   input  wire logic        sclk_in,
   input  wire logic        cs_n_in,
   input  wire logic        sdata_in,
   input  wire logic        mod_data_in,
   // Divided main VCO clock
   input  wire logic        divided_main_vco_clock_in,
   // Register contents
   output logic [11:0]      main_int_divider_out,
   output logic [11:0]      main_fraction_upper_out,
   output logic [11:0]      main_fraction_lower_out,
   output logic [11:0]      aux_int_divider_out,
   output logic [11:0]      aux_fraction_out,
   output logic [11:0]      ref_clock_dividers_out,
   output logic [11:0]      detector_gain_control_out,
   output logic [11:0]      powerdown_outsel_control_out,
   output logic [11:0]      mod_path_control_out,
   output logic [11:0]      mod_sample_out,
   // Modulator side
   output logic [11:0]      applied_sample_out,
   output logic             sample_strobe_out,
   output logic             sample_pending_out,
   output logic [19:0]      frac_offset_out
);

   localparam logic [4:0] ONE_BIT = 5'h01;

   // Synchroniser and edge history
   logic [`PIN_COUNT-1:0] pins;
   logic [`PIN_COUNT-1:0] sync1_r;
   logic [`PIN_COUNT-1:0] sync2_r;
   logic [`PIN_COUNT-1:0] prev_r;

   // Frame capture
   synth_serial_mod_loader_pkg::frame_state_t state_r;
   synth_serial_mod_loader_pkg::frame_state_t state_nxt;
   logic [15:0]          shift_r;
   logic [11:0]          mod_shift_r;
   logic [4:0]           len_r;

   // Register file, write-only from the link
   synth_serial_mod_loader_pkg::reg_word_t regs_r [0:`REG_COUNT-1];

   // Sample path
   synth_serial_mod_loader_pkg::sample_t stage_data_r;
   logic                 stage_valid_r;
   logic [11:0]          applied_r;
   logic                 strobe_r;
   logic                 pending_r;
   logic [19:0]          offset_r;

   // Decoded strobes
   logic                 sclk_rise;
   logic                 cs_low;
   logic                 cs_fall;
   logic                 cs_rise;
   logic                 vco_fall;

   // Frame decode
   logic                 decoding;
   logic                 is_addr;
   logic                 is_short;
   synth_serial_mod_loader_pkg::reg_addr_t frame_addr;
   synth_serial_mod_loader_pkg::reg_word_t frame_data;
   logic                 addr_ok;
   logic                 reg_wr;

   // Short sample path
   logic                 sample_wr;
   logic                 mod_src_alt;
   logic [11:0]          short_raw;
   logic [3:0]           sh_amt;
   synth_serial_mod_loader_pkg::sample_t short_left;
   synth_serial_mod_loader_pkg::sample_t short_ext;
   synth_serial_mod_loader_pkg::sample_t sample_val;

   // Hand-over and offset arithmetic
   logic                 transfer;
   logic                 last_word;
   logic [2:0]           mag;
   logic signed [17:0]   dividend;
   logic signed [19:0]   sample_wide;
   logic signed [19:0]   sample_shift;
   logic signed [19:0]   offset_nxt;

   // Sample buffer between decode and modulator
   sample_stream_if #(.WIDTH(`DATA_BITS), .CNT_W(2)) stream ();

   sample_buffer #(
      .WIDTH (`DATA_BITS),
      .DEPTH (`BUF_DEPTH)
   ) u_buffer
   (
      .mclk_in (mclk_in),
      .rst_in  (rst_in),
      .st      (stream.buffer_side)
   );

   // Pins gathered into one synchroniser vector
   assign pins[`PIN_SCLK]  = sclk_in;
   assign pins[`PIN_CS_N]  = cs_n_in;
   assign pins[`PIN_SDATA] = sdata_in;
   assign pins[`PIN_MOD]   = mod_data_in;
   assign pins[`PIN_VCO]   = divided_main_vco_clock_in;

   // Two stages; only the second stage feeds edge logic
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sync1_r <= `PIN_IDLE;
         sync2_r <= `PIN_IDLE;
         prev_r  <= `PIN_IDLE;
      end
      else
      begin
         sync1_r <= pins;
         sync2_r <= sync1_r;
         prev_r  <= sync2_r;
      end
   end

   // Edge detection on resynchronised levels
   assign sclk_rise = sync2_r[`PIN_SCLK] & ~prev_r[`PIN_SCLK];
   assign cs_low    = ~sync2_r[`PIN_CS_N];
   assign cs_fall   = ~sync2_r[`PIN_CS_N] & prev_r[`PIN_CS_N];
   assign cs_rise   = sync2_r[`PIN_CS_N] & ~prev_r[`PIN_CS_N];

   // Only the falling edge of the divided clock matters
   assign vco_fall  = ~sync2_r[`PIN_VCO] & prev_r[`PIN_VCO];

   // Frame state sequencing
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         synth_serial_mod_loader_pkg::ST_IDLE:
         begin
            if (cs_fall)
               state_nxt = synth_serial_mod_loader_pkg::ST_SHIFT;
         end
         synth_serial_mod_loader_pkg::ST_SHIFT:
         begin
            if (cs_rise)
               state_nxt = synth_serial_mod_loader_pkg::ST_DECODE;
         end
         synth_serial_mod_loader_pkg::ST_DECODE:
         begin
            state_nxt = synth_serial_mod_loader_pkg::ST_IDLE;
         end
         default:
         begin
            state_nxt = synth_serial_mod_loader_pkg::ST_IDLE;
         end
      endcase
   end

   // Shift both pins; length saturates so long windows stay long
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_r     <= synth_serial_mod_loader_pkg::ST_IDLE;
         shift_r     <= 16'h0000;
         mod_shift_r <= 12'h000;
         len_r       <= 5'h00;
      end
      else
      begin
         state_r <= state_nxt;
         if (state_r == synth_serial_mod_loader_pkg::ST_IDLE && cs_fall)
            len_r <= 5'h00;
         else if (state_r == synth_serial_mod_loader_pkg::ST_SHIFT &&
                  sclk_rise && cs_low)
         begin
            shift_r     <= {shift_r[14:0], sync2_r[`PIN_SDATA]};
            mod_shift_r <= {mod_shift_r[10:0], sync2_r[`PIN_MOD]};
            if (len_r != `LEN_SAT)
               len_r <= len_r + ONE_BIT;
         end
      end
   end

   // Frame classification; the shifter keeps only the newest bits
   assign decoding = (state_r == synth_serial_mod_loader_pkg::ST_DECODE);
   assign is_addr  = (len_r >= `FRAME_BITS);
   assign is_short = (len_r >= `SHORT_MIN_BITS) &&
                     (len_r <= `SHORT_MAX_BITS);

   // Address and data fields of the newest sixteen bits
   assign frame_addr = shift_r[`ADDR_MSB:`ADDR_LSB];
   assign frame_data = shift_r[`DATA_MSB:0];
   assign addr_ok    = (frame_addr <= `ADDR_MOD_SAMPLE);
   assign reg_wr     = decoding && is_addr && addr_ok;

   // Short frame source and sign extension from its own length
   assign mod_src_alt = regs_r[`ADDR_MOD_CTRL][`MODCTL_SRC_BIT];
   assign short_raw   = mod_src_alt ? mod_shift_r
                                    : shift_r[`DATA_MSB:0];
   assign sh_amt      = 4'(`SHORT_MAX_BITS - len_r);
   assign short_left  = short_raw << sh_amt;
   assign short_ext   = short_left >>> sh_amt;

   // Either route lands in the same sample register
   assign sample_wr  = (reg_wr && frame_addr == `ADDR_MOD_SAMPLE) ||
                       (decoding && is_short);
   assign sample_val = is_short ? short_ext : frame_data;

   // Register file; only frame decoding writes, nothing reads back
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         for (int i = 0; i < `REG_COUNT; i++)
         begin
            regs_r[i] <= `RST_OTHER;
         end
         regs_r[`ADDR_MAIN_INT] <= `RST_INT_DIVIDER;
         regs_r[`ADDR_AUX_INT]  <= `RST_INT_DIVIDER;
      end
      else if (sample_wr)
         regs_r[`ADDR_MOD_SAMPLE] <= sample_val;
      else if (reg_wr)
         regs_r[frame_addr] <= frame_data;
   end

   // Staging word; a second write before the push overwrites it
   assign stream.wr_valid = stage_valid_r;
   assign stream.wr_data  = stage_data_r;
   assign stream.rd_ready = vco_fall;
   assign transfer        = stream.rd_valid & vco_fall;
   assign last_word       = (stream.rd_count == 2'h1) & ~stage_valid_r;

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         stage_valid_r <= 1'b0;
         stage_data_r  <= 12'h000;
      end
      else if (sample_wr)
      begin
         stage_valid_r <= 1'b1;
         stage_data_r  <= sample_val;
      end
      else if (stage_valid_r && stream.wr_ready)
         stage_valid_r <= 1'b0;
   end

   // Hand-over to the modulator; a new write beats the clear
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         applied_r <= 12'h000;
         strobe_r  <= 1'b0;
         pending_r <= 1'b0;
      end
      else
      begin
         strobe_r <= transfer;
         if (transfer)
            applied_r <= stream.rd_data;
         if (sample_wr)
            pending_r <= 1'b1;
         else if (transfer && last_word)
            pending_r <= 1'b0;
      end
   end

   // Dividend joins upper and lower fraction registers
   assign dividend     = $signed({regs_r[`ADDR_MAIN_FRAC_HI][`FRAC_HI_MSB:0],
                                  regs_r[`ADDR_MAIN_FRAC_LO][`FRAC_LO_MSB:0]});
   assign mag          = regs_r[`ADDR_MOD_CTRL]
                               [`MODCTL_MAG_MSB:`MODCTL_MAG_LSB];

   // Sample widened with its sign, then scaled by 2^m
   assign sample_wide  = 20'($signed(applied_r));
   assign sample_shift = sample_wide <<< mag;
   assign offset_nxt   = 20'(dividend) + sample_shift;

   // Range beyond 0.5625 step is left to software, not clipped
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         offset_r <= 20'h0_0000;
      else
         offset_r <= offset_nxt;
   end

   // Outputs straight from flip-flops
   assign main_int_divider_out         = regs_r[`ADDR_MAIN_INT];
   assign main_fraction_upper_out      = regs_r[`ADDR_MAIN_FRAC_HI];
   assign main_fraction_lower_out      = regs_r[`ADDR_MAIN_FRAC_LO];
   assign aux_int_divider_out          = regs_r[`ADDR_AUX_INT];
   assign aux_fraction_out             = regs_r[`ADDR_AUX_FRAC];
   assign ref_clock_dividers_out       = regs_r[`ADDR_REF_DIV];
   assign detector_gain_control_out    = regs_r[`ADDR_DET_GAIN];
   assign powerdown_outsel_control_out = regs_r[`ADDR_PWR_OUTSEL];
   assign mod_path_control_out         = regs_r[`ADDR_MOD_CTRL];
   assign mod_sample_out               = regs_r[`ADDR_MOD_SAMPLE];

   // Modulator side, also registered
   assign applied_sample_out           = applied_r;
   assign sample_strobe_out            = strobe_r;
   assign sample_pending_out           = pending_r;
   assign frac_offset_out              = offset_r;

endmodule : synth_serial_mod_loader

`default_nettype wire

// file: verif/serial_host_model.sv
// Host controller and sample source driving the three-wire link
`timescale 1ns/10ps
`default_nettype none

module serial_host_model
(
   // Reference clock
   input  wire logic mclk_in,
   // Serial pins
   output logic      sclk_out,
   output logic      cs_n_out,
   output logic      sdata_out,
   output logic      mod_data_out
);
   // Pins idle with select high and the clock parked low
   initial
   begin
      sclk_out     = 1'b0;
      cs_n_out     = 1'b1;
      sdata_out    = 1'b0;
      mod_data_out = 1'b0;
   end

   // Three reference cycles a phase, so the synchroniser sees each level
   task automatic half();
      repeat (3) @(negedge mclk_in);
   endtask : half

   // One select window of n bits, MSB first; unused line toggles as junk
   task automatic send(input int n, input logic [31:0] v, input bit alt);
      @(negedge mclk_in);
      cs_n_out = 1'b0;
      for (int i = n - 1; i >= 0; i--)
      begin
         sdata_out    = alt ? ~sdata_out : v[i];
         mod_data_out = alt ? v[i] : ~mod_data_out;
         half();
         sclk_out = 1'b1;
         half();
         sclk_out = 1'b0;
      end
      cs_n_out     = 1'b1;
      sdata_out    = ~sdata_out;
      mod_data_out = ~mod_data_out;
      // Long gap covers decode latency and the select spacing
      repeat (8) @(negedge mclk_in);
   endtask : send
endmodule : serial_host_model

`default_nettype wire

// file: verif/synth_serial_mod_loader_chk.sv
// Port checker for the serial loader
`timescale 1ns/10ps
`default_nettype none

module synth_serial_mod_loader_chk
(
   // Clock, reset and pins
   input wire logic        mclk_in,
   input wire logic        rst_in,
   input wire logic        cs_n_in,
   input wire logic        divided_main_vco_clock_in,
   // Registers
   input wire logic [11:0] main_int_divider_out,
   input wire logic [11:0] main_fraction_upper_out,
   input wire logic [11:0] main_fraction_lower_out,
   input wire logic [11:0] aux_int_divider_out,
   input wire logic [11:0] aux_fraction_out,
   input wire logic [11:0] ref_clock_dividers_out,
   input wire logic [11:0] detector_gain_control_out,
   input wire logic [11:0] powerdown_outsel_control_out,
   input wire logic [11:0] mod_path_control_out,
   input wire logic [11:0] mod_sample_out,
   // Modulator side
   input wire logic [11:0] applied_sample_out,
   input wire logic        sample_strobe_out,
   input wire logic        sample_pending_out,
   input wire logic [19:0] frac_offset_out
);
   logic [119:0] regs_w;
   logic [19:0]  sum_w;

   // All registers in one word; offset rebuilt from what is visible
   assign regs_w = {main_int_divider_out, main_fraction_upper_out,
      main_fraction_lower_out, aux_int_divider_out, aux_fraction_out,
      ref_clock_dividers_out, detector_gain_control_out,
      powerdown_outsel_control_out, mod_path_control_out, mod_sample_out};
   assign sum_w = {{2{main_fraction_upper_out[9]}},
      main_fraction_upper_out[9:0], main_fraction_lower_out[7:0]}
      + ({{8{applied_sample_out[11]}}, applied_sample_out}
      << mod_path_control_out[3:1]);

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   // Falling divided clock while a word waits
   sequence vco_fall_s;
      $fell(divided_main_vco_clock_in) ##0 sample_pending_out;
   endsequence

   strobe_once_a: assert property (
      sample_strobe_out |=> !sample_strobe_out)
      else $error("strobe longer than one cycle");
   vco_transfer_a: assert property (
      vco_fall_s |-> ##[1:4] sample_strobe_out)
      else $error("pending sample not transferred");
   strobe_cause_a: assert property (
      $rose(sample_strobe_out) |-> $past(sample_pending_out))
      else $error("strobe with nothing pending");
   pend_clear_a: assert property (
      $fell(sample_pending_out) |-> sample_strobe_out)
      else $error("pending dropped without transfer");
   applied_hold_a: assert property (
      $changed(applied_sample_out) |-> sample_strobe_out)
      else $error("applied sample changed without strobe");
   offset_sum_a: assert property (
      1'b1 |=> frac_offset_out == $past(sum_w))
      else $error("offset is not dividend plus shifted sample");
   regs_framed_a: assert property (
      $changed(regs_w) |-> cs_n_in && $past(cs_n_in, 3))
      else $error("register changed inside a select window");
   sample_pend_a: assert property (
      $changed(mod_sample_out) |-> sample_pending_out)
      else $error("sample written without pending flag");
endmodule : synth_serial_mod_loader_chk

bind synth_serial_mod_loader synth_serial_mod_loader_chk chk_i
(
   .mclk_in, .rst_in, .cs_n_in, .divided_main_vco_clock_in,
   .main_int_divider_out, .main_fraction_upper_out,
   .main_fraction_lower_out, .aux_int_divider_out, .aux_fraction_out,
   .ref_clock_dividers_out, .detector_gain_control_out,
   .powerdown_outsel_control_out, .mod_path_control_out, .mod_sample_out,
   .applied_sample_out, .sample_strobe_out, .sample_pending_out,
   .frac_offset_out
);

`default_nettype wire

// file: verif/tb_synth_serial_mod_loader.sv
// Self-checking bench for the serial loader
`timescale 1ns/10ps
`default_nettype none

module tb_synth_serial_mod_loader;
   logic        mclk_in;
   logic        rst_in;
   logic        vco_r;
   logic        sclk_w;
   logic        cs_n_w;
   logic        sdata_w;
   logic        mod_w;
   logic [11:0] rg [10];
   logic [11:0] exp_r [10];
   logic [11:0] applied_w;
   logic        strobe_w;
   logic        pending_w;
   logic [19:0] offset_w;
   int          err_count;
   int          comparisons;

   // Host drives the serial pins
   serial_host_model host
   (
      .mclk_in (mclk_in), .sclk_out (sclk_w), .cs_n_out (cs_n_w),
      .sdata_out (sdata_w), .mod_data_out (mod_w)
   );

   synth_serial_mod_loader dut
   (
      .mclk_in (mclk_in), .rst_in (rst_in), .sclk_in (sclk_w),
      .cs_n_in (cs_n_w), .sdata_in (sdata_w), .mod_data_in (mod_w),
      .divided_main_vco_clock_in (vco_r),
      .main_int_divider_out (rg[0]), .main_fraction_upper_out (rg[1]),
      .main_fraction_lower_out (rg[2]), .aux_int_divider_out (rg[3]),
      .aux_fraction_out (rg[4]), .ref_clock_dividers_out (rg[5]),
      .detector_gain_control_out (rg[6]),
      .powerdown_outsel_control_out (rg[7]),
      .mod_path_control_out (rg[8]), .mod_sample_out (rg[9]),
      .applied_sample_out (applied_w), .sample_strobe_out (strobe_w),
      .sample_pending_out (pending_w), .frac_offset_out (offset_w)
   );

   // Reference clock, 10 ns period
   initial mclk_in = 1'b0;
   always #5 mclk_in = ~mclk_in;

   task automatic chk(input string nm, input logic [19:0] seen,
                      input logic [19:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : end_sim

   // Sign extension of an n-bit sample to twelve bits
   function automatic logic [11:0] sx(input int n, input logic [11:0] v);
      return $signed(v << (12 - n)) >>> (12 - n);
   endfunction : sx

   // Dividend plus sample shifted by the magnitude field
   function automatic logic [19:0] exp_off(input logic [11:0] e);
      logic [19:0] d;
      d = {{2{exp_r[1][9]}}, exp_r[1][9:0], exp_r[2][7:0]};
      return d + ({{8{e[11]}}, e} << exp_r[8][3:1]);
   endfunction : exp_off

   task automatic wr(input logic [3:0] a, input logic [11:0] d);
      host.send(16, {16'h0000, a, d}, 1'b0);
      if (a < 4'hA)
         exp_r[a] = d;
   endtask : wr

   task automatic chk_regs();
      for (int i = 0; i < 10; i++)
         chk($sformatf("reg%0d", i), rg[i], exp_r[i]);
   endtask : chk_regs

   // One divided clock fall, then the handed sample and offset
   task automatic vco_pulse(input logic [11:0] e);
      @(negedge mclk_in) vco_r = 1'b1;
      repeat (4) @(negedge mclk_in);
      vco_r = 1'b0;
      for (int k = 0; k < 10 && strobe_w !== 1'b1; k++)
         @(negedge mclk_in);
      chk("strobe", strobe_w, 1'b1);
      chk("applied", applied_w, e);
      @(negedge mclk_in);
      chk("offset", offset_w, exp_off(e));
   endtask : vco_pulse

   task automatic t_reset();
      foreach (exp_r[i])
         exp_r[i] = 12'h000;
      exp_r[0] = 12'h006;
      exp_r[3] = 12'h006;
      chk_regs();
      chk("applied", applied_w, 12'h000);
      chk("pending", pending_w, 1'b0);
      chk("offset", offset_w, 20'h0_0000);
      $display("t_reset done");
   endtask : t_reset

   // Addresses 0 to 8, then an unmapped one that must change nothing
   task automatic t_addr();
      for (int i = 0; i < 9; i++)
         wr(4'(i), 12'h5A3 + 12'(i) * 12'h111);
      wr(4'hA, 12'hFFF);
      chk_regs();
      chk("pending", pending_w, 1'b0);
      $display("t_addr done");
   endtask : t_addr

   // Over-long window keeps the last bits; lengths 15, 13 and 1 are dropped
   task automatic t_long();
      host.send(20, 32'h000F_53C7, 1'b0);
      exp_r[5] = 12'h3C7;
      host.send(15, 32'h0000_6ABC, 1'b0);
      host.send(13, 32'h0000_1ABC, 1'b0);
      host.send(1, 32'h0000_0001, 1'b0);
      chk_regs();
      chk("pending", pending_w, 1'b0);
      $display("t_long done");
   endtask : t_long

   // Short frames on the primary pin, shortest to longest
   task automatic t_short();
      wr(4'h8, 12'h000);
      wr(4'h1, 12'h3FF);
      wr(4'h2, 12'h0F0);
      for (int n = 2; n <= 12; n += 5)
      begin
         host.send(n, 32'h0000_0A5B, 1'b0);
         exp_r[9] = sx(n, 12'hA5B);
         chk("sample", rg[9], exp_r[9]);
         chk("pending", pending_w, 1'b1);
         vco_pulse(exp_r[9]);
         chk("pending", pending_w, 1'b0);
      end
      $display("t_short done");
   endtask : t_short

   // Alternate pin with magnitude two, then an addressed sample
   task automatic t_alt();
      wr(4'h8, 12'h005);
      host.send(7, 32'h0000_004D, 1'b1);
      exp_r[9] = 12'hFCD;
      chk("sample", rg[9], 12'hFCD);
      vco_pulse(12'hFCD);
      wr(4'h9, 12'h123);
      chk("sample", rg[9], 12'h123);
      vco_pulse(12'h123);
      chk_regs();
      $display("t_alt done");
   endtask : t_alt

   // Three samples queue up before any transfer, leave in order
   task automatic t_buf();
      host.send(3, 32'h0000_0003, 1'b1);
      host.send(4, 32'h0000_0009, 1'b1);
      host.send(12, 32'h0000_0800, 1'b1);
      exp_r[9] = 12'h800;
      chk("pending", pending_w, 1'b1);
      vco_pulse(12'h003);
      vco_pulse(12'hFF9);
      chk("pending", pending_w, 1'b1);
      vco_pulse(12'h800);
      chk("pending", pending_w, 1'b0);
      chk_regs();
      $display("t_buf done");
   endtask : t_buf

   // Watchdog, well past the few thousand cycles the tests need
   initial
   begin
      #200us;
      err_count++;
      end_sim();
   end

   // Main sequence
   initial
   begin
      rst_in      = 1'b1;
      vco_r       = 1'b0;
      err_count   = 0;
      comparisons = 0;
      repeat (12) @(negedge mclk_in);
      rst_in = 1'b0;
      repeat (4) @(negedge mclk_in);
      t_reset();
      t_addr();
      t_long();
      t_short();
      t_alt();
      t_buf();
      end_sim();
   end
endmodule : tb_synth_serial_mod_loader

`default_nettype wire
